// ==== verilog/srss_core.sv ====
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Literal subtract puts k minus W into W and updates flags.
// - File-minus-W subtracts W from the addressed file register in two's complement.
// - Destination bit 0 writes W, 1 writes back to the file register.
// - Access bit 0 uses the access bank, 1 uses the bank select register.
// - Fill-ones writes FF to the file register and leaves all flags unchanged.
// - Sleep clears watchdog and postscaler, sets time-out, clears power-down, then sleeps.
// - Subtract carry is an inverted borrow; a borrow clears it and negative copies bit 7 of the difference.
// - Subtract sets zero when the 8-bit difference is zero, else clears it.
module srss_core
    import srss_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // Instruction issue
    input  wire logic        i_valid,
    input  wire logic [15:0] i_instr,
    // File register read data for the addressed operand
    input  wire logic [7:0]  i_file_rdata,
    // Bank select register write
    input  wire logic        i_bank_we,
    input  wire logic [3:0]  i_bank_wdata,
    // Watchdog tick from its own divider
    input  wire logic        i_wdt_tick,
    // Wake from sleep
    input  wire logic        i_wake,
    // Operand address and file writes
    output logic      [11:0] o_file_addr,
    output srss_fwr_t        o_fwr,
    // Architectural state
    output logic      [7:0]  o_w,
    output srss_flags_t      o_flags,
    output logic             o_timeout_flag,
    output logic             o_powerdown_flag,
    output logic      [15:0] o_watchdog_counter,
    output logic             o_sleep
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic        is_literal_minus_working_op;
    logic        is_file_minus_working_op;
    logic        is_working_minus_file_borrow_op;
    logic        is_rlnc;
    logic        is_rrnc;
    logic        is_rrc;
    logic        is_fill_ones_op;
    logic        is_sleep;
    logic        is_sub;
    logic        dst_file;
    logic [7:0]  fa;
    logic [3:0]  bank_q;
    logic [7:0]  w_q;
    srss_flags_t flags_q;
    logic [7:0]  post_q;
    logic [15:0] wdt_q;
    logic        to_q;
    logic        pd_q;
    logic        sleep_q;
    logic        go;

    assign go        = i_valid & ~sleep_q;
    assign fa        = i_instr[7:0];
    assign is_literal_minus_working_op  = go & (i_instr[15:8] == SRSS_LIT_SUB_OPC);
    assign is_file_minus_working_op  = go & (i_instr[15:10] == SRSS_FILE_MINUS_WORKING_OP_OPC);
    assign is_working_minus_file_borrow_op = go & (i_instr[15:10] == SRSS_WORKING_MINUS_FILE_BORROW_OP_OPC);
    assign is_rlnc   = go & (i_instr[15:10] == SRSS_RLNC_OPC);
    assign is_rrnc   = go & (i_instr[15:10] == SRSS_RRNC_OPC);
    assign is_rrc    = go & (i_instr[15:10] == SRSS_RRC_OPC);
    assign is_fill_ones_op   = go & (i_instr[15:9] == SRSS_FILL_ONES_OP_OPC);
    assign is_sleep  = go & (i_instr == SRSS_SLEEP_OPC);
    assign is_sub    = is_literal_minus_working_op | is_file_minus_working_op | is_working_minus_file_borrow_op;
    assign dst_file  = i_instr[SRSS_D_BIT];

    // Access bank splits low RAM and high SFRs around 0x80
    always_comb begin
        if (!i_instr[SRSS_A_BIT]) begin
            o_file_addr = {(fa < SRSS_ACCESS_SPLIT) ? SRSS_ACCESS_BANK_LO
                                                    : SRSS_ACCESS_BANK_HI, fa};
        end else begin
            o_file_addr = {bank_q, fa};
        end
    end

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    logic [7:0] sub_a;
    logic [7:0] sub_b;
    logic [7:0] diff;
    logic       sub_c;
    logic [7:0] res;
    logic       res_c;

    // Operand order differs per subtract form
    always_comb begin
        sub_a = i_file_rdata;
        sub_b = w_q;
        if (is_literal_minus_working_op) begin
            sub_a = fa;
        end else if (is_working_minus_file_borrow_op) begin
            sub_a = w_q;
            sub_b = i_file_rdata;
        end
    end

    srss_alu u_alu (
        .i_a         (sub_a),
        .i_b         (sub_b),
        .i_cin       (flags_q.carry),
        .i_borrow_en (is_working_minus_file_borrow_op),
        .o_diff      (diff),
        .o_carry     (sub_c)
    );

    // Result select
    always_comb begin
        res   = diff;
        res_c = sub_c;
        if (is_rlnc) begin
            res = {i_file_rdata[6:0], i_file_rdata[7]};
        end else if (is_rrnc) begin
            res = {i_file_rdata[0], i_file_rdata[7:1]};
        end else if (is_rrc) begin
            res   = {flags_q.carry, i_file_rdata[7:1]};
            res_c = i_file_rdata[0];
        end
    end

    // File write port; SLW and sleep never touch the file
    always_comb begin
        o_fwr.we   = 1'b0;
        o_fwr.addr = o_file_addr;
        o_fwr.data = res;
        if (is_fill_ones_op) begin
            o_fwr.we   = 1'b1;
            o_fwr.data = SRSS_ALL_ONES;
        end else if ((is_file_minus_working_op | is_working_minus_file_borrow_op | is_rlnc | is_rrnc | is_rrc) & dst_file) begin
            o_fwr.we = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Working register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            w_q <= SRSS_W_RST;
        end else if (is_literal_minus_working_op) begin
            w_q <= res;
        end else if ((is_file_minus_working_op | is_working_minus_file_borrow_op | is_rlnc | is_rrnc | is_rrc) & ~dst_file) begin
            w_q <= res;
        end
    end

    // Flags; fill-ones and sleep leave them alone
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flags_q <= '0;
        end else if (is_sub | is_rlnc | is_rrnc | is_rrc) begin
            flags_q.neg  <= res[7];
            flags_q.zero <= (res == 8'h00);
            if (is_sub | is_rrc) begin
                flags_q.carry <= res_c;
            end
        end
    end

    // Bank select register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bank_q <= SRSS_BANK_RST;
        end else if (i_bank_we) begin
            bank_q <= i_bank_wdata;
        end
    end

    // ------------------------------------------------------------
    // Watchdog, status bits and sleep
    // ------------------------------------------------------------
    // Postscaler wraps into the counter; sleep clear beats a tick
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            post_q <= SRSS_POST_RST;
            wdt_q  <= SRSS_WDT_RST;
        end else if (is_sleep) begin
            post_q <= SRSS_POST_RST;
            wdt_q  <= SRSS_WDT_RST;
        end else if (i_wdt_tick) begin
            post_q <= post_q + 8'h01;
            if (post_q == SRSS_ALL_ONES) begin
                wdt_q <= wdt_q + 16'h0001;
            end
        end
    end

    // Power-on shows TO=1, PD=1
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end else if (is_sleep) begin
            to_q <= 1'b1;
            pd_q <= 1'b0;
        end
    end

    // Oscillator stop modelled as an issue gate until wake
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sleep_q <= 1'b0;
        end else if (is_sleep) begin
            sleep_q <= 1'b1;
        end else if (i_wake) begin
            sleep_q <= 1'b0;
        end
    end

    assign o_w                = w_q;
    assign o_flags            = flags_q;
    assign o_timeout_flag     = to_q;
    assign o_powerdown_flag   = pd_q;
    assign o_watchdog_counter = wdt_q;
    assign o_sleep            = sleep_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_literal_minus_working_op_result: assert property (@(posedge i_clk) disable iff (!i_nrst)
        is_literal_minus_working_op |=> (w_q == $past(fa) - $past(w_q)))
        else $error("literal subtract result wrong");
    a_file_minus_working_op_dest: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (is_file_minus_working_op & dst_file) |-> (o_fwr.we && o_fwr.data == i_file_rdata - w_q))
        else $error("file minus W write wrong");
    a_dest_w: assert property (@(posedge i_clk) disable iff (!i_nrst)
        ((is_file_minus_working_op | is_rrnc) & ~dst_file) |-> !o_fwr.we ##1 (w_q == $past(res)))
        else $error("destination W not honoured");
    a_bank_sel: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (go & i_instr[SRSS_A_BIT]) |-> (o_file_addr[11:8] == bank_q))
        else $error("bank select ignored");
    a_fill_ones_op_flags: assert property (@(posedge i_clk) disable iff (!i_nrst)
        is_fill_ones_op |-> (o_fwr.we && o_fwr.data == SRSS_ALL_ONES) ##1 $stable(flags_q))
        else $error("fill ones wrong");
    a_sleep_state: assert property (@(posedge i_clk) disable iff (!i_nrst)
        is_sleep |=> (wdt_q == 16'h0000 && post_q == 8'h00 && to_q && !pd_q && sleep_q))
        else $error("sleep entry wrong");
    a_sub_carry: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (is_file_minus_working_op && i_file_rdata < w_q) |=>
            (!flags_q.carry &&
             (flags_q.neg == (($past(i_file_rdata) - $past(w_q)) >= 8'h80))))
        else $error("borrow carry wrong");
    a_sub_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (is_file_minus_working_op && i_file_rdata == w_q) |=> (flags_q.zero && flags_q.carry))
        else $error("zero flag wrong");
    a_rrc_carry: assert property (@(posedge i_clk) disable iff (!i_nrst)
        is_rrc |=> (flags_q.carry == $past(i_file_rdata[0])))
        else $error("rotate carry wrong");
    a_working_minus_file_borrow_op_val: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (is_working_minus_file_borrow_op & ~dst_file) |=>
            (w_q == $past(w_q) - $past(i_file_rdata) - {7'h00, ~$past(flags_q.carry)}))
        else $error("borrow subtract wrong");

    c_sleep:  cover property (@(posedge i_clk) disable iff (!i_nrst) is_sleep ##[1:20] i_wake);
    c_fill_ones_op:   cover property (@(posedge i_clk) disable iff (!i_nrst) is_fill_ones_op);
    c_borrow: cover property (@(posedge i_clk) disable iff (!i_nrst) is_working_minus_file_borrow_op & ~flags_q.carry);
    c_rrc:    cover property (@(posedge i_clk) disable iff (!i_nrst) is_rrc & dst_file);

endmodule

`default_nettype wire

// ==== verilog/srss_pkg.sv ====
package srss_pkg;

    // ------------------------------------------------------------
    // Opcode patterns (upper bits of the 16-bit instruction, all 16 bits for sleep)
    // ------------------------------------------------------------
    localparam logic [7:0] SRSS_LIT_SUB_OPC    = 8'h08; // literal_minus_working_op
    localparam logic [5:0] SRSS_FILE_MINUS_WORKING_OP_OPC      = 6'h17; // file_minus_working_op 0101 11
    localparam logic [5:0] SRSS_WORKING_MINUS_FILE_BORROW_OP_OPC     = 6'h15; // working_minus_file_borrow_op 0101 01
    localparam logic [5:0] SRSS_RLNC_OPC       = 6'h11; // rotate_left_plain_op 0100 01
    localparam logic [5:0] SRSS_RRNC_OPC       = 6'h10; // rotate_right_plain_op 0100 00
    localparam logic [5:0] SRSS_RRC_OPC        = 6'h0C; // rotate_right_via_carry_op 0011 00
    localparam logic [6:0] SRSS_FILL_ONES_OP_OPC       = 7'h34; // fill_ones_op 0110 100
    localparam logic [15:0] SRSS_SLEEP_OPC     = 16'h0003;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          SRSS_D_BIT         = 9;
    localparam int          SRSS_A_BIT         = 8;
    localparam logic [7:0]  SRSS_ALL_ONES      = 8'hFF;
    localparam logic [7:0]  SRSS_W_RST         = 8'h00;
    localparam logic [3:0]  SRSS_BANK_RST      = 4'h0;
    localparam logic [3:0]  SRSS_ACCESS_BANK_LO = 4'h0;
    localparam logic [3:0]  SRSS_ACCESS_BANK_HI = 4'hF;
    localparam logic [7:0]  SRSS_ACCESS_SPLIT  = 8'h80;
    localparam int          SRSS_WDT_W         = 16;
    localparam logic [15:0] SRSS_WDT_RST       = 16'h0000;
    localparam logic [7:0]  SRSS_POST_RST      = 8'h00;

    // Status flags travel together
    typedef struct packed {
        logic neg;
        logic zero;
        logic carry;
    } srss_flags_t;

    // File write request
    typedef struct packed {
        logic        we;
        logic [11:0] addr;
        logic [7:0]  data;
    } srss_fwr_t;

endpackage

// ==== verilog/srss_alu.sv ====
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Combinational subtract unit (rotates are done in the core)
// ------------------------------------------------------------
module srss_alu
    import srss_pkg::*;
(
    // Operands
    input  wire logic [7:0]  i_a,
    input  wire logic [7:0]  i_b,
    input  wire logic        i_cin,
    input  wire logic        i_borrow_en,
    // Results
    output logic      [7:0]  o_diff,
    output logic             o_carry
);

    logic [8:0] sum;

    // a - b - !c as a + ~b + c; bit 8 is the inverted borrow
    always_comb begin
        sum = {1'b0, i_a} + {1'b0, ~i_b} + {8'h00, (i_borrow_en ? i_cin : 1'b1)};
        o_diff  = sum[7:0];
        o_carry = sum[8];
    end

endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import srss_pkg::*;

    // ----------------------------------------------------------
    // Signals and design instance
    // ----------------------------------------------------------
    logic        i_clk, i_nrst, i_valid, i_bank_we, i_wdt_tick, i_wake;
    logic [15:0] i_instr;
    logic [7:0]  i_file_rdata;
    logic [3:0]  i_bank_wdata;
    logic [11:0] o_file_addr;
    srss_fwr_t   o_fwr;
    logic [7:0]  o_w;
    srss_flags_t o_flags;
    logic        o_timeout_flag, o_powerdown_flag, o_sleep;
    logic [15:0] o_watchdog_counter;
    int          error_cnt, total_checks, cyc, post;
    logic [7:0]  mw, rnd;
    logic        mc, mz, mn, mto, mpd, msl;
    logic [3:0]  mbank;
    logic [15:0] mwdt;
    logic [15:0] base [8] = '{16'h5C00, 16'h5400, 16'h4400, 16'h4000, 16'h3000,
                              16'h6800, 16'h0800, 16'h0000};
    logic [15:0] mask [8] = '{16'h03FF, 16'h03FF, 16'h03FF, 16'h03FF, 16'h03FF,
                              16'h01FF, 16'h00FF, 16'h0000};

    srss_core dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid), .i_instr(i_instr),
        .i_file_rdata(i_file_rdata), .i_bank_we(i_bank_we), .i_bank_wdata(i_bank_wdata),
        .i_wdt_tick(i_wdt_tick), .i_wake(i_wake), .o_file_addr(o_file_addr), .o_fwr(o_fwr),
        .o_w(o_w), .o_flags(o_flags), .o_timeout_flag(o_timeout_flag),
        .o_powerdown_flag(o_powerdown_flag), .o_watchdog_counter(o_watchdog_counter),
        .o_sleep(o_sleep));

    // 200 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // Hang guard, well above the roughly one thousand cycles the tests need
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            complete_run();
        end
    end

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (error_cnt == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One cycle of stimulus, launched at the rising edge
    task automatic drv(input logic v, input logic [15:0] ins, input logic [7:0] fd,
                       input logic bwe, input logic tick, input logic wake);
        @(posedge i_clk);
        i_valid      <= v;
        i_instr      <= ins;
        i_file_rdata <= fd;
        i_bank_we    <= bwe;
        i_bank_wdata <= fd[3:0];
        i_wdt_tick   <= tick;
        i_wake       <= wake;
    endtask

    // Registered state compared mid-cycle, after the previous edge settled
    task automatic state_chk();
        @(negedge i_clk);
        chk(o_w, mw);
        chk(o_flags, {mn, mz, mc});
        chk(o_sleep, msl);
        chk({o_timeout_flag, o_powerdown_flag}, {mto, mpd});
        chk(o_watchdog_counter, mwdt);
    endtask

    // ----------------------------------------------------------
    // Instruction issue with the reference model
    // ----------------------------------------------------------
    task automatic exec(input logic [15:0] ins, input logic [7:0] fd);
        logic [7:0]  f, r;
        logic [8:0]  t;
        logic [11:0] ad;
        logic [5:0]  op;
        logic        wf, fop, sub, rot;
        drv(1'b1, ins, fd, 1'b0, 1'b0, 1'b0);
        state_chk();
        f  = ins[7:0];
        op = ins[15:10];
        ad = ins[SRSS_A_BIT] ? {mbank, f} : (f < 8'h80 ? {4'h0, f} : {4'hF, f});
        wf = 1'b0; fop = 1'b1; sub = 1'b0; rot = 1'b0; r = 8'h00; t = 9'h000;
        if (msl) begin
            chk(o_fwr.we, 1'b0);
            return;
        end
        if (ins == SRSS_SLEEP_OPC) begin
            fop = 1'b0; msl = 1'b1; mto = 1'b1; mpd = 1'b0; mwdt = 16'h0000; post = 0;
        end else if (ins[15:8] == SRSS_LIT_SUB_OPC) begin
            fop = 1'b0; t = {1'b0, f} - {1'b0, mw}; sub = 1'b1;
        end else if (op == SRSS_FILE_MINUS_WORKING_OP_OPC) begin
            t = {1'b0, fd} - {1'b0, mw}; sub = 1'b1;
        end else if (op == SRSS_WORKING_MINUS_FILE_BORROW_OP_OPC) begin
            t = {1'b0, mw} - {1'b0, fd} - {8'h00, ~mc}; sub = 1'b1;
        end else if (op == SRSS_RLNC_OPC) begin
            r = {fd[6:0], fd[7]}; rot = 1'b1;
        end else if (op == SRSS_RRNC_OPC) begin
            r = {fd[0], fd[7:1]}; rot = 1'b1;
        end else if (op == SRSS_RRC_OPC) begin
            r = {mc, fd[7:1]}; mc = fd[0]; rot = 1'b1;
        end else if (ins[15:9] == SRSS_FILL_ONES_OP_OPC) begin
            r = SRSS_ALL_ONES; wf = 1'b1;
        end else begin
            fop = 1'b0;
        end
        if (sub) begin
            r = t[7:0];
            mc = ~t[8];
        end
        if (sub || rot) begin
            mz = (r == 8'h00);
            mn = r[7];
            if (ins[15:8] == SRSS_LIT_SUB_OPC || !ins[SRSS_D_BIT]) mw = r;
            else wf = 1'b1;
        end
        if (fop) chk(o_file_addr, ad);
        chk(o_fwr.we, wf);
        if (wf) chk({o_fwr.addr, o_fwr.data}, {ad, r});
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        error_cnt = 0; total_checks = 0; post = 0; rnd = 8'hE8;
        i_nrst = 1'b0; i_valid = 1'b0; i_instr = 16'h0000; i_file_rdata = 8'h00;
        i_bank_we = 1'b0; i_bank_wdata = 4'h0; i_wdt_tick = 1'b0; i_wake = 1'b0;
        mw = SRSS_W_RST; {mn, mz, mc} = 3'b000; mbank = SRSS_BANK_RST;
        mto = 1'b1; mpd = 1'b1; msl = 1'b0; mwdt = 16'h0000;
        repeat (20) @(posedge i_clk);
        state_chk(); // Values held in reset
        @(posedge i_clk);
        i_nrst <= 1'b1;
        // Literal subtract: positive, zero and negative results
        exec(16'h0801, 8'h00);
        foreach (base[k]) exec(16'h0800 | 16'(k), 8'h00);
        exec(16'h0803, 8'h00);
        exec(16'h0802, 8'h00);
        // Back-to-back random traffic with bank changes
        for (int n = 0; n < 400; n++) begin
            rnd = lfsr(rnd);
            if (n % 16 == 0) begin
                drv(1'b0, 16'h0000, rnd, 1'b1, 1'b0, 1'b0);
                mbank = rnd[3:0];
            end
            rnd = lfsr(rnd);
            exec(base[rnd[2:0]] | ({rnd[7:6], 8'h00} & mask[rnd[2:0]]) |
                 ({8'h00, lfsr(rnd)} & mask[rnd[2:0]]), lfsr(lfsr(rnd)));
        end
        // Watchdog advances, then sleep clears it
        repeat (520) begin
            drv(1'b0, 16'h0000, 8'h00, 1'b0, 1'b1, 1'b0);
            post = post + 1;
            if (post == 256) begin
                post = 0;
                mwdt = mwdt + 16'h0001;
            end
        end
        exec(SRSS_SLEEP_OPC, 8'h00);
        exec(16'h0855, 8'h00); // Ignored while asleep
        drv(1'b0, 16'h0000, 8'h00, 1'b0, 1'b0, 1'b1);
        msl = 1'b0;
        drv(1'b0, 16'h0000, 8'h00, 1'b0, 1'b0, 1'b0);
        state_chk();
        exec(16'h0855, 8'h00);
        drv(1'b0, 16'h0000, 8'h00, 1'b0, 1'b0, 1'b0);
        state_chk();
        complete_run();
    end

endmodule

`default_nettype wire
